// [mtc_training_control.sv]
/*
 * training control register of the modem data pump, with the mode field,
 * detection flags, transmit sequence decode and a flag interrupt.
 * assumes a classic wishbone master on clk, detector pulses/levels from
 * the receiver on clk, and a transmitter that follows txSequence.
 */
// How it works
// - reset loads training register with zero
// - standby or data mode write clears it
// - data mode freezes training register contents
// - bit7 scrambled ones after 30 ms debounce
// - bit6 S1 pattern after 27 ms debounce
// - bit5 plain marks at 1200 bps
// - bit4 scrambled zeros seen
// - phase modes: codes 0-4 select sequences
// - phase modes: 5, 6 start data
// - phase mode tone, default 2225 Hz
// - fsk: squelch, marks, spaces, data
// - fsk tone via tone A frequency
// - mode codes 8,9,A,B,D,E
`timescale 1ns/100ps
`include "mtc_params.svh"
module mtc_training_control
    import mtc_pkg::*;
#(
    parameter int scrOnesDebCycles = `MTC_SCR_ONES_DEB_CYC,
    parameter int s1DebCycles = `MTC_S1_DEB_CYC,
    parameter int adrWidth = 12
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [adrWidth-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scrambledOnesRaw,
    input wire logic s1PatternRaw,
    input wire logic plainMarksRaw,
    input wire logic scrambledZerosRaw,
    output mtc_tx_t txSequence,
    output logic [6:0] operatingMode,
    output logic dataModeActive,
    output logic force16Way,
    output logic [11:0] toneDefaultHz,
    output logic irq
);

    initial
    begin
        if (adrWidth < 12)
            $error("mtc_training_control: adrWidth must be at least 12");
    end

    // ----------------------------------------
    // debounce length checks
    // ----------------------------------------
    initial
    begin
        if (scrOnesDebCycles < 1)
            $error("mtc_training_control: scrOnesDebCycles must be at least 1");
        if (s1DebCycles < 1)
            $error("mtc_training_control: s1DebCycles must be at least 1");
    end

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic [7:0] train_reg;
    logic [7:0] train_next;
    logic [6:0] mode_reg;
    logic [3:0] irqStatus_reg;
    logic [3:0] irqMask_reg;
    mtc_state_t state_reg;
    logic access;
    logic wrLow;
    logic selTrain;
    logic selMode;
    logic selStatus;
    logic selMask;
    logic modeWrite;
    logic modeClears;
    logic [3:0] detNow;
    logic [3:0] detSeen;
    logic scrOnesDeb;
    logic s1Deb;

    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrLow = access && wb_we_i && wb_sel_i[0];
    assign selTrain = wb_adr_i[11:0] == `MTC_TRAIN_IDX;
    assign selMode = wb_adr_i[11:0] == `MTC_MODE_IDX;
    assign selStatus = wb_adr_i[11:0] == `MTC_IRQ_STATUS_IDX;
    assign selMask = wb_adr_i[11:0] == `MTC_IRQ_MASK_IDX;
    assign modeWrite = wrLow && selMode;

    // standby or any data mode clears training
    always_comb
    begin
        unique case (mtc_mode_t'(wb_dat_i[6:0]))
            MTC_MODE_STANDBY, MTC_MODE_V22BIS, MTC_MODE_V22, MTC_MODE_V21,
            MTC_MODE_PSK_ALT, MTC_MODE_V23_FWD, MTC_MODE_V23_REV:
                modeClears = 1'b1;
            default:
                modeClears = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= access;
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            wb_dat_o <= 32'h00000000;
        else if (access && !wb_we_i)
        begin
            if (selTrain)
                wb_dat_o <= {24'h000000, train_reg};
            else if (selMode)
                wb_dat_o <= {25'h0, mode_reg};
            else if (selStatus)
                wb_dat_o <= {28'h0000000, irqStatus_reg};
            else if (selMask)
                wb_dat_o <= {28'h0000000, irqMask_reg};
            else
                wb_dat_o <= 32'h00000000;
        end
    end

    // ----------------------------------------
    // mode field
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            mode_reg <= `MTC_MODE_RESET;
        else if (modeWrite)
            mode_reg <= wb_dat_i[6:0];
    end

    // ----------------------------------------
    // detectors
    // ----------------------------------------
    mtc_debounce #(.holdCycles(scrOnesDebCycles)) scrOnesDebounce
    (
        .clk(clk),
        .reset(reset),
        .rawIn(scrambledOnesRaw),
        .stableOut(scrOnesDeb)
    );

    mtc_debounce #(.holdCycles(s1DebCycles)) s1Debounce
    (
        .clk(clk),
        .reset(reset),
        .rawIn(s1PatternRaw),
        .stableOut(s1Deb)
    );

    assign detNow = {scrOnesDeb, s1Deb, plainMarksRaw, scrambledZerosRaw};
    assign detSeen = detNow & ~train_reg[7:4];

    // ----------------------------------------
    // training register
    // ----------------------------------------
    always_comb
    begin
        train_next = train_reg;
        if (state_reg != MTC_ST_DATA)
        begin
            train_next[7:4] = train_reg[7:4] | detNow;
            if (wrLow && selTrain)
                train_next[3:0] = wb_dat_i[3:0];
        end
        if (modeWrite && modeClears)
            train_next = `MTC_TRAIN_RESET;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            train_reg <= `MTC_TRAIN_RESET;
        else
            train_reg <= train_next;
    end

    // ----------------------------------------
    // training flow
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            state_reg <= MTC_ST_IDLE;
        else if (modeWrite)
            state_reg <= (wb_dat_i[6:0] == 7'h00) ? MTC_ST_IDLE : MTC_ST_TRAIN;
        else if (state_reg == MTC_ST_TRAIN && (train_reg[2:0] == 3'h5 || train_reg[2:0] == 3'h6))
            state_reg <= MTC_ST_DATA;
    end

    // ----------------------------------------
    // transmit sequence decode
    // ----------------------------------------
    logic fskMode;
    logic pskMode;
    mtc_tx_t tx_next;

    assign fskMode = mode_reg == MTC_MODE_V21 || mode_reg == MTC_MODE_V23_FWD || mode_reg == MTC_MODE_V23_REV;
    assign pskMode = mode_reg == MTC_MODE_V22BIS || mode_reg == MTC_MODE_V22 || mode_reg == MTC_MODE_PSK_ALT;

    always_comb
    begin
        tx_next = MTC_TX_SILENT;
        if (pskMode)
        begin
            unique case (train_reg[2:0])
                3'h0: tx_next = MTC_TX_SILENT;
                3'h1: tx_next = MTC_TX_PLAIN_ONES_1200;
                3'h2: tx_next = MTC_TX_S1;
                3'h3: tx_next = MTC_TX_SCR_ONES_1200;
                3'h4: tx_next = MTC_TX_SCR_ONES_2400;
                3'h5: tx_next = MTC_TX_DATA_1200;
                3'h6: tx_next = MTC_TX_DATA_2400;
                3'h7: tx_next = MTC_TX_TONE;
            endcase
        end
        else if (fskMode)
        begin
            unique case (train_reg[2:0])
                3'h1: tx_next = MTC_TX_FSK_MARKS;
                3'h2: tx_next = MTC_TX_FSK_SPACES;
                3'h5: tx_next = MTC_TX_FSK_DATA;
                3'h7: tx_next = MTC_TX_TONE;
                default: tx_next = MTC_TX_SILENT;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            txSequence <= MTC_TX_SILENT;
        else if (state_reg != MTC_ST_DATA)
            txSequence <= tx_next;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            operatingMode <= `MTC_MODE_RESET;
            dataModeActive <= 1'b0;
            force16Way <= 1'b0;
            toneDefaultHz <= 12'h000;
        end
        else
        begin
            operatingMode <= mode_reg;
            dataModeActive <= state_reg == MTC_ST_DATA;
            force16Way <= train_reg[`MTC_BIT_FORCE16] && mode_reg == MTC_MODE_V22BIS;
            toneDefaultHz <= 12'(`MTC_TONE_DEFAULT_HZ);
        end
    end

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            irqStatus_reg <= 4'h0;
        else if (access && !wb_we_i && selStatus)
            irqStatus_reg <= detSeen;
        else
            irqStatus_reg <= irqStatus_reg | detSeen;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irqMask_reg <= `MTC_MASK_RESET;
        else if (wrLow && selMask)
            irqMask_reg <= wb_dat_i[3:0];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(irqStatus_reg & irqMask_reg);
    end

endmodule

// [mtc_params.svh]
/*
 * constants for the modem training control block: offsets, field
 * positions, reset values and debounce times.
 * assumes a 40 MHz system clock and byte addressing on the register bus.
 */
`ifndef MTC_PARAMS_SVH
`define MTC_PARAMS_SVH

// ----------------------------------------
// register indices and reset values
// ----------------------------------------
`define MTC_TRAIN_IDX 12'h1FE
`define MTC_MODE_IDX 12'h1FF
`define MTC_IRQ_STATUS_IDX 12'h1FA
`define MTC_IRQ_MASK_IDX 12'h1FB
`define MTC_TRAIN_RESET 8'h00
`define MTC_MODE_RESET 7'h00
`define MTC_MASK_RESET 4'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define MTC_BIT_SCR_ONES 7
`define MTC_BIT_S1 6
`define MTC_BIT_PLAIN_MARKS 5
`define MTC_BIT_SCR_ZEROS 4
`define MTC_BIT_FORCE16 3

// ----------------------------------------
// timing
// ----------------------------------------
`define MTC_CLK_HZ 40000000
`define MTC_SCR_ONES_DEB_MS 30
`define MTC_S1_DEB_MS 27
`define MTC_SCR_ONES_DEB_CYC ((`MTC_CLK_HZ / 1000) * `MTC_SCR_ONES_DEB_MS)
`define MTC_S1_DEB_CYC ((`MTC_CLK_HZ / 1000) * `MTC_S1_DEB_MS)
`define MTC_TONE_DEFAULT_HZ 2225

`endif

// [mtc_pkg.sv]
/*
 * types for the modem training control block.
 * assumes nothing beyond the constants header.
 */
package mtc_pkg;

    // operating modes of the mode field
    typedef enum logic [6:0]
    {
        MTC_MODE_STANDBY = 7'h00,
        MTC_MODE_V22BIS = 7'h08,
        MTC_MODE_V22 = 7'h09,
        MTC_MODE_V21 = 7'h0A,
        MTC_MODE_PSK_ALT = 7'h0B,
        MTC_MODE_V23_FWD = 7'h0D,
        MTC_MODE_V23_REV = 7'h0E
    } mtc_mode_t;

    // line sequence the transmitter produces
    typedef enum logic [3:0]
    {
        MTC_TX_SILENT,
        MTC_TX_PLAIN_ONES_1200,
        MTC_TX_S1,
        MTC_TX_SCR_ONES_1200,
        MTC_TX_SCR_ONES_2400,
        MTC_TX_DATA_1200,
        MTC_TX_DATA_2400,
        MTC_TX_TONE,
        MTC_TX_FSK_MARKS,
        MTC_TX_FSK_SPACES,
        MTC_TX_FSK_DATA
    } mtc_tx_t;

    // training flow
    typedef enum logic [1:0]
    {
        MTC_ST_IDLE,
        MTC_ST_TRAIN,
        MTC_ST_DATA
    } mtc_state_t;

endpackage

// [mtc_debounce.sv]
/*
 * debouncer: output rises once the input has stood high for holdCycles
 * consecutive clocks, falls at once with the input.
 * assumes a synchronous input on clk.
 */
`timescale 1ns/100ps
module mtc_debounce
#(
    parameter int holdCycles = 1200000
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic rawIn,
    output logic stableOut
);

    localparam int cntW = $clog2(holdCycles + 1);
    logic [cntW-1:0] count_reg;

    initial
    begin
        if (holdCycles < 1)
            $error("mtc_debounce: holdCycles must be at least 1");
    end

    // ----------------------------------------
    // qualifying counter
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset || !rawIn)
            count_reg <= '0;
        else if (count_reg != cntW'(holdCycles))
            count_reg <= count_reg + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            stableOut <= 1'b0;
        else
            stableOut <= rawIn && (count_reg == cntW'(holdCycles - 1) || count_reg == cntW'(holdCycles));
    end

endmodule

// [mtc_training_control_monitor.sv]
/*
 * checker for the training control block: bus handshake and outputs.
 * assumes it is bound to mtc_training_control on its single clock.
 */
`timescale 1ns/100ps
module mtc_training_control_monitor
    import mtc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire mtc_tx_t txSequence,
    input wire logic [6:0] operatingMode,
    input wire logic dataModeActive,
    input wire logic force16Way,
    input wire logic [11:0] toneDefaultHz,
    input wire logic irq
);
    // ----------------------------
    // handshake and output checks
    // ----------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence busTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ackPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_PULSE: assert property (busTaken |=> ackPulse)
        else $error("ack not one pulse after request");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    AST_RESET_CLEAR: assert property ($past(reset) |-> txSequence == MTC_TX_SILENT
        && operatingMode == 7'h00 && !dataModeActive && !force16Way && !irq)
        else $error("outputs not cleared by reset");
    AST_FORCE16_MODE: assert property (force16Way |-> operatingMode == 7'h08)
        else $error("force 16 way outside mode 8");
    AST_DATA_FROZEN: assert property (dataModeActive && $past(dataModeActive) |-> $stable(txSequence))
        else $error("sequence changed in data mode");
    AST_DATA_SEQ: assert property (dataModeActive |-> txSequence inside
        {MTC_TX_DATA_1200, MTC_TX_DATA_2400, MTC_TX_FSK_DATA})
        else $error("data mode without data sequence");
    AST_TONE_DEFAULT: assert property (!$past(reset) |-> toneDefaultHz == 12'h8B1)
        else $error("tone default wrong");
endmodule
bind mtc_training_control mtc_training_control_monitor u_monitor (.clk(clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .txSequence(txSequence), .operatingMode(operatingMode), .dataModeActive(dataModeActive),
    .force16Way(force16Way), .toneDefaultHz(toneDefaultHz), .irq(irq));

// [mtc_line_model.sv]
/*
 * remote modem seen through the receiver detectors.
 * assumes the bench chooses which patterns are on the line.
 */
`timescale 1ns/100ps
module mtc_line_model
(
    input wire logic clk,
    input wire logic [3:0] lineSend,
    output logic scrambledOnesRaw = 1'b0,
    output logic s1PatternRaw = 1'b0,
    output logic plainMarksRaw = 1'b0,
    output logic scrambledZerosRaw = 1'b0
);
    // detector levels follow the line one clock late
    always @(posedge clk)
    begin
        {scrambledOnesRaw, s1PatternRaw, plainMarksRaw, scrambledZerosRaw} <= lineSend;
    end
endmodule

// [testbench.sv]
/*
 * self-checking bench for the training control block.
 * assumes the monitor and line model are compiled first.
 */
`timescale 1ns/100ps
`include "mtc_params.svh"
module testbench
    import mtc_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack, sOnes, sS1, sMarks, sZeros, dataOn, force16, irq;
    logic [3:0] lineSend = 4'h0;
    logic [6:0] mode;
    logic [11:0] toneHz;
    mtc_tx_t txSeq;
    int nErrors = 0;
    int comparisons = 0;
    logic [3:0] pskCode [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
    logic [3:0] fskCode [4] = '{4'h0, 4'h1, 4'h2, 4'h7};
    logic [3:0] fskExp [4] = '{4'h0, 4'h8, 4'h9, 4'h7};
    logic [31:0] dMode [3] = '{32'h8, 32'h9, 32'hA};
    logic [31:0] dCode [3] = '{32'h6, 32'h5, 32'h5};
    logic [3:0] dExp [3] = '{4'h6, 4'h5, 4'hA};
    always #12.5 clk = ~clk;
    mtc_training_control #(.scrOnesDebCycles(20), .s1DebCycles(16)) u_mtc_training_control (.clk(clk),
        .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .scrambledOnesRaw(sOnes), .s1PatternRaw(sS1),
        .plainMarksRaw(sMarks), .scrambledZerosRaw(sZeros), .txSequence(txSeq), .operatingMode(mode),
        .dataModeActive(dataOn), .force16Way(force16), .toneDefaultHz(toneHz), .irq(irq));
    mtc_line_model u_mtc_line_model (.clk(clk), .lineSend(lineSend), .scrambledOnesRaw(sOnes),
        .s1PatternRaw(sS1), .plainMarksRaw(sMarks), .scrambledZerosRaw(sZeros));
    // ----------------------------
    // bus tasks and comparison
    // ----------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out();
        if (nErrors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            nErrors++;
            close_out();
        end
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // ----------------------------
    // scenarios
    // ----------------------------
    initial
    begin
        int i;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(`MTC_TRAIN_IDX, 32'h0);
        rd(`MTC_IRQ_MASK_IDX, 32'h0);
        rd(12'h100, 32'h0);
        check({20'h0, toneHz}, 32'h8B1);
        xfer(1'b1, `MTC_IRQ_MASK_IDX, 32'hF);
        xfer(1'b1, `MTC_MODE_IDX, 32'h8);
        rd(`MTC_MODE_IDX, 32'h8);
        check({25'h0, mode}, 32'h8);
        xfer(1'b1, `MTC_TRAIN_IDX, 32'hFF);
        rd(`MTC_TRAIN_IDX, 32'hF);
        check({31'h0, force16}, 32'h1);
        for (i = 0; i < 6; i++)
        begin
            xfer(1'b1, `MTC_TRAIN_IDX, {28'h0, pskCode[i]});
            check({28'h0, txSeq}, {28'h0, pskCode[i]});
        end
        xfer(1'b1, `MTC_MODE_IDX, 32'hA);
        rd(`MTC_MODE_IDX, 32'hA);
        check({25'h0, mode}, 32'hA);
        check({31'h0, force16}, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            xfer(1'b1, `MTC_TRAIN_IDX, {28'h0, fskCode[i]});
            check({28'h0, txSeq}, {28'h0, fskExp[i]});
        end
        xfer(1'b1, `MTC_MODE_IDX, 32'h8);
        lineSend <= 4'h3;
        repeat (3) @(posedge clk);
        rd(`MTC_TRAIN_IDX, 32'h30);
        check({31'h0, irq}, 32'h1);
        rd(`MTC_IRQ_STATUS_IDX, 32'h3);
        check({31'h0, irq}, 32'h0);
        lineSend <= 4'hC;
        repeat (12) @(posedge clk);
        lineSend <= 4'h0;
        rd(`MTC_TRAIN_IDX, 32'h30);
        lineSend <= 4'hC;
        repeat (24) @(posedge clk);
        rd(`MTC_TRAIN_IDX, 32'hF0);
        rd(`MTC_IRQ_STATUS_IDX, 32'hC);
        lineSend <= 4'h0;
        xfer(1'b1, `MTC_TRAIN_IDX, 32'h3);
        xfer(1'b1, `MTC_MODE_IDX, 32'h9);
        rd(`MTC_TRAIN_IDX, 32'h0);
        for (i = 0; i < 3; i++)
        begin
            xfer(1'b1, `MTC_MODE_IDX, dMode[i]);
            xfer(1'b1, `MTC_TRAIN_IDX, dCode[i]);
            xfer(1'b1, `MTC_TRAIN_IDX, 32'h1);
            rd(`MTC_TRAIN_IDX, dCode[i]);
            check({31'h0, dataOn}, 32'h1);
            check({28'h0, txSeq}, {28'h0, dExp[i]});
            xfer(1'b1, `MTC_MODE_IDX, 32'h0);
            rd(`MTC_TRAIN_IDX, 32'h0);
            check({31'h0, dataOn}, 32'h0);
        end
        xfer(1'b1, `MTC_MODE_IDX, 32'h8);
        xfer(1'b1, `MTC_TRAIN_IDX, 32'h2);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(`MTC_TRAIN_IDX, 32'h0);
        rd(`MTC_MODE_IDX, 32'h0);
        close_out();
    end
endmodule
